// >>> hdl/acs_seq.sv
// conversion sequencer top: modes, priming, start trigger, done output
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_seq #(
  parameter int RW = 20
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // register port
  input  wire logic [`ACS_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [31:0]                 rdata,
  // converter side
  input  wire logic                   start_trig,
  input  wire logic                   mod_bit,
  output logic                        mod_reset,
  // result side
  output logic                        conv_done,
  output logic                        irq
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] trig_s_q;
  logic [1:0] bit_s_q;
  logic       trig_old_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_s_q   <= 2'h0;
      bit_s_q    <= 2'h0;
      trig_old_q <= 1'b0;
    end else begin
      trig_s_q   <= {trig_s_q[0], start_trig};
      bit_s_q    <= {bit_s_q[0], mod_bit};
      trig_old_q <= trig_s_q[1];
    end
  end
  wire trig_rise = trig_s_q[1] & ~trig_old_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic             en_q;
  acs_mode_t        mode_q;
  logic [4:0]       res_q;
  logic [15:0]      period_q;
  logic [2:0]       stat_q;
  logic [2:0]       mask_q;
  logic [RW-1:0]    result_q;
  logic             done_q;
  logic [31:0]      rdata_q;
  logic             irq_q;
  logic             mrst_q;

  wire wr_ctrl   = wr & (addr == `ACS_A_CTRL);
  wire wr_cfg    = wr & (addr == `ACS_A_CFG);
  wire wr_mask   = wr & (addr == `ACS_A_MASK);
  wire wr_period = wr & (addr == `ACS_A_PERIOD);
  wire rd_stat   = rd & (addr == `ACS_A_STAT);
  wire rd_result = rd & (addr == `ACS_A_RESULT);
  wire sw_start  = wr_ctrl & wdata[`ACS_CTRL_START];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  acs_state_t  st_q;
  logic [1:0]  prime_q;
  logic [15:0] tick_q;
  logic        run_q;
  logic        multi_reset;
  wire         busy      = (st_q != ACS_IDLE);
  wire         is_cont   = (mode_q == ACS_CONT);
  wire         turbo_hi  = (mode_q == ACS_TURBO) &
                           (res_q >= `ACS_TURBO_RES);
  wire         start_req = en_q & (sw_start | trig_rise);
  wire         go        = start_req & ~busy;
  wire         period_end = busy & (tick_q == period_q);
  wire         last_prime = (st_q == ACS_PRIME) &
                            (prime_q == `ACS_PRIME_CNT - 2'h1);
  wire         conv_end  = period_end & (st_q == ACS_CONV);
  // multi and low-res turbo re-prime each sample; high-res turbo does not
  wire         reprime   = (mode_q == ACS_MULTI) |
                           ((mode_q == ACS_TURBO) & ~turbo_hi);
  wire [RW-1:0] dec_val;

  acs_decim #(.W(RW)) u_decim (
    .clk    (clk),
    .resetn (resetn),
    .clr    (multi_reset),
    .dump   (period_end),
    .bit_in (bit_s_q[1]),
    .bit_en (busy),
    .value  (dec_val)
  );

  acs_state_t st_d;
  always_comb begin
    st_d        = st_q;
    multi_reset = 1'b0;
    unique case (st_q)
      ACS_IDLE: begin
        if (go) begin
          st_d        = ACS_PRIME;
          multi_reset = 1'b1;
        end
      end
      ACS_PRIME: begin
        if (period_end && last_prime) begin
          st_d = ACS_CONV;
        end
      end
      ACS_CONV: begin
        if (conv_end) begin
          if (!run_q || mode_q == ACS_SINGLE) begin
            st_d = ACS_IDLE;
          end else if (is_cont) begin
            st_d = ACS_CONV;
          end else if (reprime) begin
            st_d        = ACS_PRIME;
            multi_reset = 1'b1;
          end else begin
            st_d = ACS_CONV;
          end
        end
      end
      default: st_d = ACS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= ACS_IDLE;
      prime_q <= 2'h0;
      tick_q  <= 16'h0;
      run_q   <= 1'b0;
      mrst_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      mrst_q  <= multi_reset;
      tick_q  <= (!busy || period_end || multi_reset) ? 16'h0
                 : tick_q + 16'h1;
      if (multi_reset)
        prime_q <= 2'h0;
      else if (period_end && st_q == ACS_PRIME)
        prime_q <= prime_q + 2'h1;
      if (go)
        run_q <= 1'b1;
      else if (!en_q)
        run_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register writes, status, result, done
  // ----------------------------------------------------------------
  wire ovr_ev = conv_end & done_q & ~rd_result;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_q     <= 1'b0;
      mode_q   <= ACS_SINGLE;
      res_q    <= `ACS_RES_RST;
      period_q <= `ACS_PERIOD_RST;
      mask_q   <= 3'h0;
      stat_q   <= 3'h0;
      result_q <= '0;
      done_q   <= 1'b0;
    end else begin
      if (wr_cfg) begin
        en_q   <= wdata[`ACS_CFG_EN];
        mode_q <= acs_mode_t'(wdata[`ACS_CFG_MODE_HI:`ACS_CFG_MODE_LO]);
        res_q  <= wdata[`ACS_CFG_RES_HI:`ACS_CFG_RES_LO];
      end
      if (wr_period)
        period_q <= wdata[15:0];
      if (wr_mask)
        mask_q <= wdata[2:0];
      if (conv_end)
        result_q <= dec_val;
      // set wins over the read clear
      stat_q[`ACS_ST_DONE] <= conv_end |
                              (stat_q[`ACS_ST_DONE] & ~rd_stat);
      stat_q[`ACS_ST_OVR]  <= ovr_ev |
                              (stat_q[`ACS_ST_OVR] & ~rd_stat);
      stat_q[`ACS_ST_BUSY] <= busy;
      done_q <= conv_end | (done_q & ~rd_result);
    end
  end

  wire [31:0] rd_mux =
    (addr == `ACS_A_CFG)    ? {24'h0, res_q, mode_q, en_q} :
    (addr == `ACS_A_STAT)   ? {29'h0, stat_q} :
    (addr == `ACS_A_MASK)   ? {29'h0, mask_q} :
    (addr == `ACS_A_RESULT) ? {{(32-RW){1'b0}}, result_q} :
    (addr == `ACS_A_PERIOD) ? {16'h0, period_q} : 32'h0;
  wire irq_d = |(stat_q[1:0] & mask_q[1:0]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= rd ? rd_mux : 32'h0;
      irq_q   <= irq_d;
    end
  end

  assign rdata     = rdata_q;
  assign irq       = irq_q;
  assign conv_done = done_q;
  assign mod_reset = mrst_q;
endmodule : acs_seq

// >>> hdl/acs_cfg.svh
// constants for the conversion sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_ADDR_W      4
`define ACS_A_CTRL      4'h0
`define ACS_A_CFG       4'h1
`define ACS_A_STAT      4'h2
`define ACS_A_MASK      4'h3
`define ACS_A_RESULT    4'h4
`define ACS_A_PERIOD    4'h5
`define ACS_CTRL_START  0
`define ACS_CFG_EN      0
`define ACS_CFG_MODE_LO 1
`define ACS_CFG_MODE_HI 2
`define ACS_CFG_RES_LO  3
`define ACS_CFG_RES_HI  7
`define ACS_ST_DONE     0
`define ACS_ST_OVR      1
`define ACS_ST_BUSY     2
`define ACS_PRIME_CNT   2'h3
`define ACS_TURBO_RES   5'h11
`define ACS_PERIOD_RST  16'h0040
`define ACS_RES_RST     5'h10
`endif

// >>> hdl/acs_pkg.sv
// types for the conversion sequencer
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_SINGLE = 2'b00,
    ACS_CONT   = 2'b01,
    ACS_MULTI  = 2'b10,
    ACS_TURBO  = 2'b11
  } acs_mode_t;
  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_PRIME = 2'b01,
    ACS_CONV  = 2'b10
  } acs_state_t;
endpackage : acs_pkg

// >>> hdl/acs_decim.sv
// sinc-style accumulate and dump decimator on the modulator stream
`timescale 1ns/10ps
module acs_decim #(
  parameter int W = 20
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // control
  input  wire logic         clr,
  input  wire logic         dump,
  input  wire logic         bit_in,
  input  wire logic         bit_en,
  // output
  output logic [W-1:0]      value
);
  logic [W-1:0] acc_q;
  logic [W-1:0] stage_q;
  wire  [W-1:0] acc_inc = acc_q + {{(W-1){1'b0}}, bit_in};
  wire  [W-1:0] acc_d   = clr ? '0 : (dump ? '0 : (bit_en ? acc_inc : acc_q));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q   <= '0;
      stage_q <= '0;
    end else begin
      acc_q   <= acc_d;
      stage_q <= clr ? '0 : (dump ? acc_q + stage_q : stage_q);
    end
  end
  assign value = stage_q;
endmodule : acs_decim

// >>> verif/acs_seq_asserts.sv
// assertions on the conversion sequencer ports
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_seq_chk (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   resetn,
  // register port
  input wire logic [`ACS_ADDR_W-1:0] addr,
  input wire logic [31:0]            wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [31:0]            rdata,
  // converter and result side
  input wire logic                   mod_reset,
  input wire logic                   conv_done,
  input wire logic                   irq
);
  logic [15:0] per_q;
  logic [15:0] cnt_q;
  logic [1:0]  mask_q;
  wire         rd_res = rd && addr == `ACS_A_RESULT;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_q  <= `ACS_PERIOD_RST;
      mask_q <= 2'h0;
      cnt_q  <= 16'h0;
    end else begin
      if (wr && addr == `ACS_A_PERIOD) per_q <= wdata[15:0];
      if (wr && addr == `ACS_A_MASK) mask_q <= wdata[1:0];
      cnt_q <= mod_reset ? 16'h0 : cnt_q + {15'h0, ~&cnt_q};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  done_hold_a:
    assert property (conv_done && !rd_res |=> conv_done) else $error("drop");
  done_fall_a:
    assert property ($fell(conv_done) |-> $past(rd_res)) else $error("fall");
  rst_pulse_a:
    assert property (mod_reset |=> !mod_reset) else $error("long reset");
  prime_time_a:
    assert property ($rose(conv_done) |-> {2'h0, cnt_q} >= {per_q, 2'h0})
      else $error("result too early");
  irq_mask_a:
    assert property ($rose(irq) |-> $past(mask_q) != 2'h0) else $error("irq");
  irq_done_a:
    assert property ($rose(conv_done) && mask_q[0] |-> ##[0:2] irq)
      else $error("no irq");
  irq_fall_a:
    assert property ($fell(irq) |-> $past(rd, 2) || $past(wr, 2))
      else $error("irq fell");
  rd_quiet_a:
    assert property (!rd |=> rdata == 32'h0) else $error("rdata");
  cover property ($rose(conv_done));
  cover property (mod_reset);
  cover property ($rose(irq));
endmodule : acs_seq_chk
bind acs_seq acs_seq_chk u_chk (.clk(clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mod_reset(mod_reset),
  .conv_done(conv_done), .irq(irq));

// >>> verif/acs_mod_src.sv
// modulator bitstream source
`timescale 1ns/10ps
module acs_mod_src (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // converter side
  input  wire logic mod_reset,
  output logic      mod_bit
);
  logic [1:0] acc_q;
  // one steady input, three quarter scale
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) acc_q <= 2'h0;
    else acc_q <= mod_reset ? 2'h0 : acc_q + 2'h3;
  end
  assign mod_bit = acc_q != 2'h0;
endmodule : acs_mod_src

// >>> verif/tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`include "acs_cfg.svh"
module tb_top;
  import acs_pkg::*;
  logic                   clk, resetn, wr, rd, start_trig;
  logic                   mod_bit, mod_reset, conv_done, irq;
  logic [`ACS_ADDR_W-1:0] addr;
  logic [31:0]            wdata, rdata, v;
  int                     err_total = 0, n_compared = 0, n, n_rst = 0;
  acs_seq u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .start_trig(start_trig),
    .mod_bit(mod_bit), .mod_reset(mod_reset), .conv_done(conv_done),
    .irq(irq));
  acs_mod_src u_mod (.clk(clk), .resetn(resetn), .mod_reset(mod_reset),
    .mod_bit(mod_bit));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (mod_reset === 1'b1) n_rst++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rreg
  task automatic wait_done();
    for (n = 0; conv_done !== 1'b1 && n < 400; n++) @(negedge clk);
  endtask : wait_done
  task automatic cfg(input acs_mode_t m, input logic [4:0] r);
    wreg(`ACS_A_CFG, {24'h0, r, m, 1'b1});
  endtask : cfg
  task automatic t_regs();
    rreg(`ACS_A_PERIOD);
    chk(v, {16'h0, `ACS_PERIOD_RST});
    rreg(4'hf);
    chk(v, 32'h0);
    wreg(`ACS_A_PERIOD, 32'hf);
  endtask : t_regs
  task automatic t_single(input logic hw);
    wreg(`ACS_A_MASK, {31'h0, ~hw});
    cfg(ACS_SINGLE, 5'h10);
    if (hw) begin
      start_trig <= 1'b1;
      repeat (4) @(posedge clk);
      start_trig <= 1'b0;
    end else wreg(`ACS_A_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    wreg(`ACS_A_CTRL, 32'h1);
    wait_done();
    chk(32'(n > 30 && n < 50), 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, {31'h0, ~hw});
    rreg(`ACS_A_STAT);
    chk(v & 32'h3, 32'h1);
    rreg(`ACS_A_RESULT);
    chk({31'h0, conv_done}, 32'h0);
    repeat (80) @(posedge clk);
    chk({30'h0, conv_done, irq}, 32'h0);
  endtask : t_single
  task automatic t_rep(input acs_mode_t m, input logic [4:0] r, input logic mu);
    cfg(m, r);
    wreg(`ACS_A_CTRL, 32'h1);
    n_rst = 0;
    wait_done();
    chk(32'(n > 58 && n < 70), 32'h1);
    rreg(`ACS_A_RESULT);
    wait_done();
    chk(32'(mu ? n > 50 && n < 70 : n < 18), 32'h1);
    chk(32'(n_rst > 1), {31'h0, mu});
    wreg(`ACS_A_CFG, 32'h0);
    repeat (80) @(posedge clk);
    rreg(`ACS_A_RESULT);
    rreg(`ACS_A_STAT);
  endtask : t_rep
  task automatic summarize();
    $display("mismatches %0d of %0d compared", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    {wr, rd, start_trig, resetn} = 4'h0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_single(1'b0);
    t_single(1'b1);
    t_rep(ACS_CONT, 5'h10, 1'b0);
    t_rep(ACS_MULTI, 5'h10, 1'b1);
    t_rep(ACS_TURBO, 5'h10, 1'b1);
    t_rep(ACS_TURBO, 5'h11, 1'b0);
    summarize();
  end
  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule : tb_top
